// ===== sync_serial_port_map.vh
// Register offsets, field positions, mode codes and divider counts.
`ifndef SYNC_SERIAL_PORT_MAP_VH
`define SYNC_SERIAL_PORT_MAP_VH

// ---------------------------------------------------------------
// Register byte offsets (one aligned 32-bit word each)
// ---------------------------------------------------------------
`define OFS_STATUS     5'h00
`define OFS_CONTROL    5'h04
`define OFS_BUFFER     5'h08
`define OFS_SLV_ADDR   5'h0c
`define OFS_DIRECTION  5'h10

// ---------------------------------------------------------------
// Status register bit positions
// ---------------------------------------------------------------
`define ST_SAMPLE 7
`define ST_CKE   6
`define ST_DA    5
`define ST_STOP  4
`define ST_START 3
`define ST_RW    2
`define ST_REWRITE 1
`define ST_FULL  0

// ---------------------------------------------------------------
// Control register bit positions
// ---------------------------------------------------------------
`define CT_WCOL  7
`define CT_OV    6
`define CT_EN    5
`define CT_POL   4

// ---------------------------------------------------------------
// Mode select codes
// ---------------------------------------------------------------
`define MODE_M4      4'h0
`define MODE_M16     4'h1
`define MODE_M64     4'h2
`define MODE_MTMR2   4'h3
`define MODE_SLV_SS  4'h4
`define MODE_SLV     4'h5
`define MODE_I2C_10A 4'h7
`define MODE_I2C_10S 4'hf

// ---------------------------------------------------------------
// Half-period counts of the master clock (count reaches value)
// ---------------------------------------------------------------
`define HALF_DIV4    5'h01
`define HALF_DIV16   5'h07
`define HALF_DIV64   5'h1f
`define EDGES_FRAME  5'h10
`define BITS_FRAME   4'h8
`define LAST_BIT     4'h7
`define ZERO8        8'h00

`endif

// ===== sync_serial_port_status.v
// Synchronous serial port: SPI shifter, APB registers, I2C status flags.
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ps
`include "sync_serial_port_map.vh"

module sync_serial_port_status (
  // Clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // APB slave
  input  wire       psel,
  input  wire       penable,
  input  wire       pwrite,
  input  wire [4:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire       pready,
  output wire       pslverr,
  // SPI pins (enables active low)
  input  wire       sck_in,
  output reg        sck_out,
  output wire       sck_oe_n,
  output reg        sdo_out,
  output wire       sdo_oe_n,
  input  wire       sdi_in,
  input  wire       ss_n_in,
  // Timer 2 match pulse, same clock
  input  wire       tmr2_pulse,
  // I2C engine events, same clock
  input  wire       i2c_start_det,
  input  wire       i2c_stop_det,
  input  wire       i2c_ack_det,
  input  wire       i2c_addr_match,
  input  wire       i2c_rw_in,
  input  wire       i2c_byte_done,
  input  wire       i2c_byte_is_data,
  input  wire       i2c_rx_valid,
  input  wire [7:0] i2c_rx_data,
  input  wire       i2c_tx_done,
  input  wire       i2c_update_addr,
  // To the I2C engine
  output reg  [7:0] i2c_tx_data,
  output reg        i2c_tx_load,
  output reg  [7:0] slave_address_register
);

  // -------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------
  reg        input_sample_phase;        // Status bit 7
  reg        clock_edge_select;         // Status bit 6
  reg        data_not_address;          // Status bit 5
  reg        stop_seen;                 // Status bit 4
  reg        start_seen;                // Status bit 3
  reg        read_not_write;            // Status bit 2
  reg        address_rewrite_flag;      // Status bit 1
  reg        buffer_full_flag;          // Status bit 0
  reg        write_collision;           // Control bit 7
  reg        receive_overflow;          // Control bit 6
  reg        port_enable_bit;           // Control bit 5
  reg        clock_idle_polarity;       // Control bit 4
  reg  [3:0] port_mode_select;          // Control bits 3:0
  reg  [7:0] serial_buffer;             // Last received byte
  reg        data_output_direction_bit; // Stored direction, 1 = input

  // -------------------------------------------------------------
  // Pin synchronisers
  // -------------------------------------------------------------
  reg  [1:0] sck_sync;                  // Bit 0 read only by bit 1
  reg  [1:0] sdi_sync;
  reg  [1:0] ss_sync;
  reg        sck_prev;                  // Previous synced clock

  // -------------------------------------------------------------
  // Shift engine state
  // -------------------------------------------------------------
  reg        busy;                      // Master frame running
  reg  [4:0] edge_cnt;                  // Master clock edges issued
  reg  [3:0] bit_cnt;                   // Bits sampled this frame
  reg        sample_pending;            // Late sample awaiting tick
  reg        lead_seen;                 // First leading edge passed
  reg  [7:0] tx_shift;                  // Outgoing byte
  reg  [7:0] serial_shift_register;     // Incoming byte
  reg  [4:0] div_cnt;                   // Master clock divider

  // -------------------------------------------------------------
  // Decodes
  // -------------------------------------------------------------
  wire spi_mode    = port_enable_bit && (port_mode_select <= `MODE_SLV);
  wire master_mode = spi_mode && (port_mode_select <= `MODE_MTMR2);
  wire slave_mode  = spi_mode && !master_mode;
  wire i2c_mode    = port_enable_bit && !spi_mode;
  wire ten_bit     = (port_mode_select == `MODE_I2C_10A) ||
                     (port_mode_select == `MODE_I2C_10S);
  wire ss_ctrl     = port_mode_select == `MODE_SLV_SS;
  wire ss_high     = ss_sync[1];
  wire slave_reset = slave_mode && ss_ctrl && ss_high;
  wire [7:0] status_word = {input_sample_phase, clock_edge_select,
                            data_not_address, stop_seen, start_seen,
                            read_not_write, address_rewrite_flag,
                            buffer_full_flag};
  // Direction readback is forced high by slave-select so a
  // read-modify-write stores the set bit and parks the output
  wire dir_readback = slave_reset | data_output_direction_bit;

  // APB strobes; pready is always high, no wait states
  wire setup_ph = psel && !penable;
  wire acc_wr   = psel && penable && pwrite;
  wire acc_rd   = psel && penable && !pwrite;
  wire mapped   = (paddr == `OFS_STATUS)  || (paddr == `OFS_CONTROL) ||
                  (paddr == `OFS_BUFFER)  || (paddr == `OFS_SLV_ADDR) ||
                  (paddr == `OFS_DIRECTION);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  wire wr_status = acc_wr && (paddr == `OFS_STATUS);
  wire wr_ctrl   = acc_wr && (paddr == `OFS_CONTROL);
  wire wr_buf    = acc_wr && (paddr == `OFS_BUFFER);
  wire wr_addr   = acc_wr && (paddr == `OFS_SLV_ADDR);
  wire wr_dir    = acc_wr && (paddr == `OFS_DIRECTION);
  wire rd_buf    = acc_rd && (paddr == `OFS_BUFFER);

  // Master half-period tick from the divider or timer 2
  reg  [4:0] half_lim;
  always @* begin
    case (port_mode_select)
      `MODE_M4:  half_lim = `HALF_DIV4;
      `MODE_M16: half_lim = `HALF_DIV16;
      default:   half_lim = `HALF_DIV64;
    endcase
  end
  wire tick = busy && ((port_mode_select == `MODE_MTMR2) ? tmr2_pulse :
                       (div_cnt == half_lim));

  // Leading edge leaves the idle level, trailing returns to it
  wire m_edge   = tick && (edge_cnt < `EDGES_FRAME);
  wire s_change = slave_mode && !slave_reset && (sck_sync[1] != sck_prev);
  wire lead_ev  = master_mode ? (m_edge && !edge_cnt[0]) :
                  (s_change && (sck_sync[1] != clock_idle_polarity));
  wire trail_ev = master_mode ? (m_edge && edge_cnt[0]) :
                  (s_change && (sck_sync[1] == clock_idle_polarity));
  // Edge bit 1 puts data change on the trailing edge so it is
  // stable on the leading one; edge bit 0 the reverse
  wire mid_ev   = clock_edge_select ? lead_ev : trail_ev;
  wire out_ev   = clock_edge_select ? trail_ev : (lead_ev && lead_seen);
  // Late sampling only in master; slave ignores the sample-phase
  // bit and always samples on the middle event
  wire late     = master_mode && input_sample_phase;
  wire samp_ev  = late ? (sample_pending && tick) : mid_ev;
  wire byte_done = samp_ev && (bit_cnt == `LAST_BIT);
  wire frame_end = busy && (edge_cnt == `EDGES_FRAME) &&
                   (bit_cnt == `BITS_FRAME);
  wire xfer_busy = master_mode ? busy : (bit_cnt != 4'h0);

  // -------------------------------------------------------------
  // Pin outputs
  // -------------------------------------------------------------
  assign sck_oe_n = !master_mode;
  assign sdo_oe_n = !(spi_mode && !dir_readback);

  // -------------------------------------------------------------
  // Synchronisers for pins
  // -------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_sync <= 2'h0;
      sdi_sync <= 2'h0;
      ss_sync  <= 2'h3;
      sck_prev <= 1'b0;
    end else begin
      sck_sync <= {sck_sync[0], sck_in};
      sdi_sync <= {sdi_sync[0], sdi_in};
      // Keeps the pin level: a high stage means deselected
      ss_sync  <= {ss_sync[0], ss_n_in};
      sck_prev <= sck_sync[1];
    end
  end

  // -------------------------------------------------------------
  // APB read data, captured in the setup phase
  // -------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_ph) begin
      case (paddr)
        `OFS_STATUS:    prdata <= {24'h00_0000, status_word};
        `OFS_CONTROL:   prdata <= {24'h00_0000, write_collision,
                                   receive_overflow, port_enable_bit,
                                   clock_idle_polarity, port_mode_select};
        `OFS_BUFFER:    prdata <= {24'h00_0000, serial_buffer};
        `OFS_SLV_ADDR:  prdata <= {24'h00_0000, slave_address_register};
        `OFS_DIRECTION: prdata <= {31'h0000_0000, dir_readback};
        default:        prdata <= 32'h0000_0000;
      endcase
    end
  end

  // -------------------------------------------------------------
  // Control, address and direction registers
  // -------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_collision           <= 1'b0;
      receive_overflow          <= 1'b0;
      port_enable_bit           <= 1'b0;
      clock_idle_polarity       <= 1'b0;
      port_mode_select          <= 4'h0;
      slave_address_register    <= `ZERO8;
      data_output_direction_bit <= 1'b1;
      input_sample_phase        <= 1'b0;
      clock_edge_select         <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        // Flags clear only by software; a set below wins
        write_collision     <= pwdata[`CT_WCOL];
        receive_overflow    <= pwdata[`CT_OV];
        port_enable_bit     <= pwdata[`CT_EN];
        clock_idle_polarity <= pwdata[`CT_POL];
        port_mode_select    <= pwdata[3:0];
      end
      if (wr_status) begin
        // Lower six bits belong to hardware and ignore writes
        input_sample_phase <= pwdata[`ST_SAMPLE];
        clock_edge_select  <= pwdata[`ST_CKE];
      end
      if (wr_addr) begin
        slave_address_register <= pwdata[7:0];
      end
      if (wr_dir) begin
        data_output_direction_bit <= pwdata[0];
      end
      // Write while shifting is dropped and flagged
      if (wr_buf && spi_mode && xfer_busy) begin
        write_collision <= 1'b1;
      end
      // Slave byte landing on a full buffer is lost
      if (byte_done && slave_mode && buffer_full_flag && !rd_buf) begin
        receive_overflow <= 1'b1;
      end
      if (i2c_mode && i2c_rx_valid && buffer_full_flag && !rd_buf) begin
        receive_overflow <= 1'b1;
      end
    end
  end

  // -------------------------------------------------------------
  // Master clock divider and clock pin
  // -------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 5'h00;
      sck_out <= 1'b0;
    end else begin
      if (!busy || tick) begin
        div_cnt <= 5'h00;
      end else begin
        div_cnt <= div_cnt + 5'h01;
      end
      if (!busy) begin
        sck_out <= clock_idle_polarity;
      end else if (m_edge) begin
        sck_out <= ~sck_out;
      end
    end
  end

  // -------------------------------------------------------------
  // Shift engine: both directions move together, MSB first
  // -------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy                  <= 1'b0;
      edge_cnt              <= 5'h00;
      bit_cnt               <= 4'h0;
      sample_pending        <= 1'b0;
      lead_seen             <= 1'b0;
      tx_shift              <= `ZERO8;
      serial_shift_register <= `ZERO8;
      sdo_out               <= 1'b0;
    end else if (!spi_mode || slave_reset) begin
      // Disabled port or deselected slave restarts the frame
      busy           <= 1'b0;
      edge_cnt       <= 5'h00;
      bit_cnt        <= 4'h0;
      sample_pending <= 1'b0;
      lead_seen      <= 1'b0;
    end else begin
      if (wr_buf && !xfer_busy) begin
        // First bit is presented before the first clock edge
        tx_shift <= pwdata[7:0];
        sdo_out  <= pwdata[7];
        busy     <= master_mode;
        edge_cnt <= 5'h00;
        bit_cnt  <= 4'h0;
        lead_seen <= 1'b0;
      end else begin
        if (m_edge) begin
          edge_cnt <= edge_cnt + 5'h01;
        end
        if (lead_ev) begin
          lead_seen <= 1'b1;
        end
        if (out_ev) begin
          tx_shift <= {tx_shift[6:0], 1'b0};
          sdo_out  <= tx_shift[6];
        end
        if (samp_ev) begin
          serial_shift_register <= {serial_shift_register[6:0],
                                    sdi_sync[1]};
          sample_pending <= 1'b0;
        end else if (late && mid_ev) begin
          sample_pending <= 1'b1;
        end
        if (byte_done && slave_mode) begin
          bit_cnt   <= 4'h0;
          lead_seen <= 1'b0;
        end else if (samp_ev) begin
          bit_cnt <= bit_cnt + 4'h1;
        end
        if (frame_end) begin
          busy <= 1'b0;
        end
      end
    end
  end

  // -------------------------------------------------------------
  // Receive buffer and buffer-full flag
  // -------------------------------------------------------------
  wire [7:0] rx_byte = {serial_shift_register[6:0], sdi_sync[1]};
  wire spi_land = byte_done && (master_mode || !buffer_full_flag ||
                                rd_buf);
  wire i2c_land = i2c_mode && i2c_rx_valid &&
                  (!buffer_full_flag || rd_buf);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_buffer    <= `ZERO8;
      buffer_full_flag <= 1'b0;
      i2c_tx_data      <= `ZERO8;
      i2c_tx_load      <= 1'b0;
    end else begin
      i2c_tx_load <= wr_buf && i2c_mode;
      if (wr_buf && i2c_mode) begin
        i2c_tx_data <= pwdata[7:0];
      end
      if (!port_enable_bit) begin
        buffer_full_flag <= 1'b0;
      end else if (spi_land) begin
        serial_buffer    <= rx_byte;
        buffer_full_flag <= 1'b1;
      end else if (i2c_land) begin
        serial_buffer    <= i2c_rx_data;
        buffer_full_flag <= 1'b1;
      end else if (wr_buf && i2c_mode) begin
        buffer_full_flag <= 1'b1;
      end else if (i2c_mode && i2c_tx_done) begin
        buffer_full_flag <= 1'b0;
      end else if (rd_buf) begin
        buffer_full_flag <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------
  // I2C status flags, fed by the bus engine
  // -------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_not_address     <= 1'b0;
      stop_seen            <= 1'b0;
      start_seen           <= 1'b0;
      read_not_write       <= 1'b0;
      address_rewrite_flag <= 1'b0;
    end else if (!i2c_mode) begin
      // Disabled port or SPI use leaves every flag clear
      data_not_address     <= 1'b0;
      stop_seen            <= 1'b0;
      start_seen           <= 1'b0;
      read_not_write       <= 1'b0;
      address_rewrite_flag <= 1'b0;
    end else begin
      if (i2c_byte_done) begin
        data_not_address <= i2c_byte_is_data;
      end
      if (i2c_stop_det) begin
        stop_seen  <= 1'b1;
        start_seen <= 1'b0;
      end else if (i2c_start_det) begin
        start_seen <= 1'b1;
        stop_seen  <= 1'b0;
      end
      // Direction holds only from match to next start, stop or ack
      if (i2c_addr_match) begin
        read_not_write <= i2c_rw_in;
      end else if (i2c_start_det || i2c_stop_det || i2c_ack_det) begin
        read_not_write <= 1'b0;
      end
      if (ten_bit && i2c_update_addr) begin
        address_rewrite_flag <= 1'b1;
      end else if (wr_addr) begin
        address_rewrite_flag <= 1'b0;
      end
    end
  end

endmodule

// ===== sync_serial_port_chk.sv
// Port assertions for the serial port block.
`timescale 1ns/1ps
module sync_serial_port_chk (
  // Clock and reset
  input wire        pclk,
  input wire        presetn,
  // APB side
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [4:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Pin and engine side
  input wire        sck_out,
  input wire        sck_oe_n,
  input wire        i2c_tx_load,
  input wire [7:0]  slave_address_register
);
  // Access phase, offsets off the map, buffer write, low data byte
  wire       acc = psel && penable;
  wire       bad = (paddr > 5'h10) || (paddr[1:0] != 2'h0);
  wire       buf_wr = acc && pwrite && (paddr == 5'h08);
  wire [7:0] wbyte = pwdata[7:0];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  bad_refused_a: assert property (acc && bad |-> pslverr)
    else $error("unmapped access taken");
  good_taken_a: assert property (acc && !bad |-> pready && !pslverr)
    else $error("mapped access refused");
  read_width_a: assert property (prdata[31:8] == 24'h0)
    else $error("read data above byte");
  read_hold_a: assert property (!psel |=> $stable(prdata))
    else $error("read data moved while idle");
  load_pulse_a: assert property (i2c_tx_load |=> !i2c_tx_load)
    else $error("load longer than a cycle");
  load_cause_a: assert property (i2c_tx_load |-> $past(buf_wr))
    else $error("load without buffer write");
  addr_write_a:
    assert property (acc && pwrite && paddr == 5'h0c |=>
      slave_address_register == $past(wbyte))
    else $error("slave address not taken");
  sck_half_a:
    assert property (!sck_oe_n && $changed(sck_out) |=> $stable(sck_out))
    else $error("master clock half period too short");
endmodule
bind sync_serial_port_status sync_serial_port_chk chk_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sck_out(sck_out),
  .sck_oe_n(sck_oe_n), .i2c_tx_load(i2c_tx_load),
  .slave_address_register(slave_address_register));

// ===== spi_far_end.sv
// Behavioural SPI peripheral on the port's master pins.
`timescale 1ns/1ps
module spi_far_end (
  // Link pins
  input wire       sck,
  input wire       mosi,
  output reg       miso,
  // Frame control
  input wire       active,
  input wire [7:0] tx_byte,
  output reg [7:0] rx_byte
);
  reg [7:0] shift; // Outgoing bits, top bit on the line
  initial miso = 1'b0;
  // Top bit goes out ahead of the first edge
  always @(posedge active) begin
    shift = tx_byte;
    miso = tx_byte[7];
  end
  // Released line shows the inverse, never a stale copy
  always @(negedge active) miso = ~miso;
  // Idle low, edge bit one: capture rising, change falling
  always @(posedge sck) if (active) rx_byte = {rx_byte[6:0], mosi};
  always @(negedge sck) if (active) begin
    shift = {shift[6:0], 1'b0};
    miso = shift[7];
  end
endmodule

// ===== sync_serial_port_status_bench.sv
// Bench: registers, master frame, slave select, I2C flags.
`timescale 1ns/1ps
module sync_serial_port_status_bench;
  // Stimulus
  reg         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  reg         pwrite = 1'b0, ss_n = 1'b1, rw_lvl = 1'b0, data_lvl = 1'b0;
  reg         far_on = 1'b0, lclk = 1'b0;
  reg  [4:0]  paddr = 5'h00;
  reg  [31:0] pwdata = 32'h0, rd;
  reg  [7:0]  ev = 8'h00, rx_lvl = 8'h00, far_tx = 8'h00;
  // Observed
  wire [31:0] prdata;
  wire [7:0]  tx_data, slv_addr, far_rx;
  wire        pready, pslverr, sck, sck_oe_n, serial_data_output, sdo_oe_n, miso, tx_load;
  integer     fail_count = 0, comparisons = 0, i;
  always #20 pclk = ~pclk;
  sync_serial_port_status sync_serial_port_status_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sck_in(lclk), .sck_out(sck),
    .sck_oe_n(sck_oe_n), .sdo_out(serial_data_output), .sdo_oe_n(sdo_oe_n),
    .sdi_in(miso), .ss_n_in(ss_n), .tmr2_pulse(1'b0),
    .i2c_start_det(ev[7]), .i2c_stop_det(ev[6]), .i2c_ack_det(ev[5]),
    .i2c_addr_match(ev[4]), .i2c_rw_in(rw_lvl), .i2c_byte_done(ev[3]),
    .i2c_byte_is_data(data_lvl), .i2c_rx_valid(ev[2]),
    .i2c_rx_data(rx_lvl), .i2c_tx_done(ev[1]), .i2c_update_addr(ev[0]),
    .i2c_tx_data(tx_data), .i2c_tx_load(tx_load),
    .slave_address_register(slv_addr));
  // Port clocks the link as master; the bench clocks it otherwise
  spi_far_end spi_far_end_inst (.sck(sck_oe_n ? lclk : sck), .mosi(serial_data_output),
    .miso(miso), .active(far_on), .tx_byte(far_tx), .rx_byte(far_rx));
  task check(input reg [31:0] got, input reg [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  // One APB transfer, held until pready is seen
  task apb(input reg wr, input reg [4:0] a, input reg [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
        @(posedge pclk);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rd_chk(input reg [4:0] a, input reg [31:0] exp);
    begin
      apb(1'b0, a, 32'h0);
      check(rd, exp);
    end
  endtask
  // Engine event pulse, then status readback
  task ev_chk(input reg [7:0] m, input reg [31:0] exp);
    begin
      @(posedge pclk);
      ev <= m;
      @(posedge pclk);
      ev <= 8'h00;
      rd_chk(5'h00, exp);
    end
  endtask
  task stop_test;
    begin
      if (fail_count == 0 && comparisons > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(5'h00, 32'h00);
    rd_chk(5'h14, 32'h00);
    apb(1'b1, 5'h00, 32'hff);
    rd_chk(5'h00, 32'hc0);
    apb(1'b1, 5'h00, 32'h40);
    apb(1'b1, 5'h10, 32'h00);
    apb(1'b1, 5'h04, 32'h21);
    far_tx <= 8'h3c;
    far_on <= 1'b1;
    apb(1'b1, 5'h08, 32'ha5);
    apb(1'b1, 5'h08, 32'h11); // Busy frame must drop this one
    rd = 32'h0;
    for (i = 0; i < 100 && rd[0] !== 1'b1; i = i + 1)
      apb(1'b0, 5'h00, 32'h0);
    check(rd, 32'h41);
    check({24'h0, far_rx}, 32'ha5);
    rd_chk(5'h04, 32'ha1);
    rd_chk(5'h08, 32'h3c);
    rd_chk(5'h00, 32'h40);
    far_on <= 1'b0;
    check({31'h0, sdo_oe_n}, 32'h0);
    repeat (20) @(posedge pclk);
    apb(1'b1, 5'h04, 32'h31);
    repeat (2) @(negedge pclk);
    check({31'h0, sck}, 32'h1);
    apb(1'b1, 5'h04, 32'h24);
    repeat (4) @(posedge pclk);
    rd_chk(5'h10, 32'h01);
    check({31'h0, sdo_oe_n}, 32'h1);
    ss_n <= 1'b0;
    repeat (4) @(posedge pclk);
    rd_chk(5'h10, 32'h00);
    // Selected slave: bench clocks eight bits, half period 8 cycles
    far_tx <= 8'hc3;
    far_on <= 1'b1;
    apb(1'b1, 5'h08, 32'h5a);
    repeat (16) begin
      repeat (8) @(posedge pclk);
      lclk <= ~lclk;
    end
    repeat (8) @(posedge pclk);
    rd_chk(5'h00, 32'h41);
    rd_chk(5'h08, 32'hc3);
    check({24'h0, far_rx}, 32'h5a);
    far_on <= 1'b0;
    apb(1'b1, 5'h00, 32'h00);
    apb(1'b1, 5'h04, 32'h27);
    rw_lvl <= 1'b1;
    data_lvl <= 1'b1;
    rx_lvl <= 8'h81;
    ev_chk(8'h80, 32'h08);
    ev_chk(8'h10, 32'h0c);
    ev_chk(8'h20, 32'h08);
    ev_chk(8'h08, 32'h28);
    ev_chk(8'h40, 32'h30);
    ev_chk(8'h01, 32'h32);
    apb(1'b1, 5'h0c, 32'h5a);
    rd_chk(5'h00, 32'h30);
    ev_chk(8'h04, 32'h31);
    rd_chk(5'h08, 32'h81);
    apb(1'b1, 5'h08, 32'h77);
    rd_chk(5'h00, 32'h31);
    check({24'h0, tx_data}, 32'h77);
    ev_chk(8'h02, 32'h30);
    apb(1'b1, 5'h04, 32'h07);
    rd_chk(5'h00, 32'h00);
    stop_test;
  end
  // Cuts a hang short well past the expected run length
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count = fail_count + 1;
    $display("[FAIL] %0t watchdog expired", $time);
    stop_test;
  end
endmodule
